// File: verilog/branch_pkg.sv
package branch_pkg;
  // Condition opcodes; alias pairs share one code
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_CARRY = 4'h1;
  localparam logic [3:0] OP_NO_CARRY = 4'h2;
  localparam logic [3:0] OP_ZERO = 4'h3;
  localparam logic [3:0] OP_NONZERO = 4'h4;
  localparam logic [3:0] OP_OVERFLOW = 4'h5;
  localparam logic [3:0] OP_NO_OVERFLOW = 4'h6;
  localparam logic [3:0] OP_NEGATIVE = 4'h7;
  localparam logic [3:0] OP_POSITIVE = 4'h8;
  localparam logic [3:0] OP_SIGNED_GREATER = 4'h9;
  // Instruction lengths
  localparam logic [15:0] SHORT_LEN = 16'h0002;
  localparam logic [15:0] LONG_LEN = 16'h0003;
  // ALU op codes for flag model
  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_SUB = 2'h1;
  localparam logic [1:0] ALU_LOGIC = 2'h2;
  localparam logic [1:0] ALU_SHIFT = 2'h3;
  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// File: verilog/flag_unit.sv
`timescale 1ns/1ps
// Arithmetic flag generation: sign, zero, parity/overflow, carry
module flag_unit (
  // Operands
  input wire logic [1:0] i_op,
  input wire logic i_word,
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  // Flags
  output logic o_sign,
  output logic o_zero,
  output logic o_pv,
  output logic o_carry
);
  logic [15:0] a_m;
  logic [15:0] b_m;
  logic [16:0] sum_w;
  logic [16:0] diff_w;
  logic [16:0] res_w;
  logic [15:0] res_m;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic carry_w;
  logic ovf_w;
  logic par_w;

  // Byte operations ignore the upper operand bytes so carry comes from bit 8
  assign a_m = i_word ? i_a : {8'h00, i_a[7:0]};
  assign b_m = i_word ? i_b : {8'h00, i_b[7:0]};
  assign sum_w = {1'b0, a_m} + {1'b0, b_m};
  assign diff_w = {1'b0, a_m} - {1'b0, b_m};
  assign res_w = (i_op == branch_pkg::ALU_SUB) ? diff_w :
                 (i_op == branch_pkg::ALU_ADD) ? sum_w : {1'b0, a_m};
  assign res_m = i_word ? res_w[15:0] : {8'h00, res_w[7:0]};
  assign msb_a = i_word ? i_a[15] : i_a[7];
  assign msb_b = i_word ? i_b[15] : i_b[7];
  assign msb_r = i_word ? res_w[15] : res_w[7];
  assign carry_w = i_word ? res_w[16] : res_w[8];
  // Overflow for add and sub; parity for logic and shift
  assign ovf_w = (i_op == branch_pkg::ALU_ADD) ? (msb_a == msb_b) && (msb_r != msb_a) :
                 (msb_a != msb_b) && (msb_r != msb_a);
  assign par_w = ~(^res_m);
  assign o_sign = msb_r;
  assign o_zero = (res_m == 16'h0000);
  assign o_pv = (i_op == branch_pkg::ALU_LOGIC || i_op == branch_pkg::ALU_SHIFT) ? par_w : ovf_w;
  assign o_carry = (i_op == branch_pkg::ALU_LOGIC) ? 1'b0 : carry_w;
endmodule

// File: verilog/conditional_branch_unit.sv
`timescale 1ns/1ps
// Contract
// - Carry set: carry pair branches
// - Carry and lower share one decode
// - Short target is address plus 2 plus displacement
// - Carry clear: no-carry pair branches
// - No-carry and not-lower share decode
// - Zero set: zero pair branches
// - Zero and equal identical
// - Wrapped minimum sum sets zero flag
// - Zero clear: nonzero pair branches
// - Nonzero and not-equal identical
// - Parity/overflow set: overflow pair branches
// - Overflow and parity-even identical
// - Parity/overflow clear: no-overflow pair branches
// - No-overflow and parity-odd identical
// - Flag holds parity or signed overflow
// - Sign set: negative branches
// - Sign clear: positive branches
// - Greater: three bytes, condition (pv^s)|z==0
module conditional_branch_unit (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Branch request
  input wire logic i_valid,
  input wire logic [3:0] i_opcode,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_short_displacement,
  // ALU flag update
  input wire logic i_alu_valid,
  input wire logic [1:0] i_alu_op,
  input wire logic i_alu_word,
  input wire logic [15:0] i_alu_a,
  input wire logic [15:0] i_alu_b,
  // Results
  output logic o_done,
  output logic o_taken,
  output logic [15:0] o_next_pc,
  output logic o_sign_flag,
  output logic o_zero_flag,
  output logic o_parity_overflow_flag,
  output logic o_carry_flag
);
  logic done_reg;
  logic taken_reg;
  logic [15:0] pc_reg;
  logic sign_reg;
  logic zero_reg;
  logic pv_reg;
  logic carry_reg;
  logic new_sign;
  logic new_zero;
  logic new_pv;
  logic new_carry;
  logic cond_w;
  logic long_w;
  logic [15:0] len_w;
  logic [15:0] fall_w;
  logic [15:0] target_w;
  logic [15:0] next_pc_next;

  flag_unit u_flags (
    .i_op(i_alu_op),
    .i_word(i_alu_word),
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .o_sign(new_sign),
    .o_zero(new_zero),
    .o_pv(new_pv),
    .o_carry(new_carry)
  );

  // Condition test per opcode
  function automatic logic cond_eval(input logic [3:0] op, input logic s, input logic z,
                                     input logic pv, input logic cy);
    logic r;
    r = 1'b0;
    unique case (op)
      branch_pkg::OP_CARRY: r = cy;
      branch_pkg::OP_NO_CARRY: r = ~cy;
      branch_pkg::OP_ZERO: r = z;
      branch_pkg::OP_NONZERO: r = ~z;
      branch_pkg::OP_OVERFLOW: r = pv;
      branch_pkg::OP_NO_OVERFLOW: r = ~pv;
      branch_pkg::OP_NEGATIVE: r = s;
      branch_pkg::OP_POSITIVE: r = ~s;
      branch_pkg::OP_SIGNED_GREATER: r = ~((pv ^ s) | z);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign cond_w = cond_eval(i_opcode, sign_reg, zero_reg, pv_reg, carry_reg);
  assign long_w = (i_opcode == branch_pkg::OP_SIGNED_GREATER);
  assign len_w = long_w ? branch_pkg::LONG_LEN : branch_pkg::SHORT_LEN;
  assign fall_w = 16'(i_pc + len_w);
  assign target_w = 16'(fall_w + {{8{i_short_displacement[7]}}, i_short_displacement});
  assign next_pc_next = cond_w ? target_w : fall_w;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_reg <= 1'b0;
      taken_reg <= 1'b0;
      pc_reg <= branch_pkg::PC_RESET;
    end else begin
      done_reg <= i_valid;
      if (i_valid) begin
        taken_reg <= cond_w;
        pc_reg <= next_pc_next;
      end
    end
  end

  // Flags change only on ALU updates and on reset, which clears them
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      {sign_reg, zero_reg, pv_reg, carry_reg} <= branch_pkg::FLAGS_RESET;
    end else if (i_alu_valid) begin
      {sign_reg, zero_reg, pv_reg, carry_reg} <= {new_sign, new_zero, new_pv, new_carry};
    end
  end

  assign o_done = done_reg;
  assign o_taken = taken_reg;
  assign o_next_pc = pc_reg;
  assign o_sign_flag = sign_reg;
  assign o_zero_flag = zero_reg;
  assign o_parity_overflow_flag = pv_reg;
  assign o_carry_flag = carry_reg;
endmodule

// File: verif/branch_props.sv
`timescale 1ns/1ps
module branch_props (
  // Watched ports
  input wire logic i_ref_clk, i_reset, i_valid, i_alu_valid,
  input wire logic [3:0] i_opcode,
  input wire logic o_done, o_taken, o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag,
  input wire logic [15:0] o_next_pc
);
  wire logic gt = !((o_parity_overflow_flag ^ o_sign_flag) | o_zero_flag);
  wire logic [15:0] conds = {6'h00, gt, !o_sign_flag, o_sign_flag, !o_parity_overflow_flag,
    o_parity_overflow_flag, !o_zero_flag, o_zero_flag, !o_carry_flag, o_carry_flag, 1'b0};
  wire logic exp_tk = conds[i_opcode];
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  taken_a: assert property (i_valid |=> o_taken == $past(exp_tk))
    else $error("taken");
  carry_a: assert property (i_valid && i_opcode == 4'h1 |=> o_taken == $past(o_carry_flag)) else $error("carry");
  greater_a: assert property (i_valid && i_opcode == 4'h9 && o_zero_flag |=> !o_taken) else $error("gt");
  none_a: assert property (i_valid && i_opcode == 4'h0 |=> !o_taken) else $error("none");
  done_a: assert property (i_valid |=> o_done) else $error("done");
  quiet_a: assert property (!i_valid |=> !o_done) else $error("quiet");
  hold_a: assert property (!i_valid |=> $stable(o_next_pc)) else $error("hold");
  keep_a: assert property (!i_alu_valid |=> $stable(o_carry_flag) && $stable(o_zero_flag)) else $error("keep");
endmodule
bind conditional_branch_unit branch_props chk (.*);

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_valid = 1'b0, i_alu_valid = 1'b0, i_alu_word = 1'b0;
  logic [1:0] i_alu_op = 2'h0;
  logic [3:0] i_opcode = 4'h0;
  logic [7:0] i_short_displacement = 8'h00;
  logic [15:0] i_pc = 16'h0000, i_alu_a = 16'h0000, o_next_pc;
  wire logic [15:0] i_alu_b = i_alu_a;
  logic o_done, o_taken, o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag;
  int n_errors = 0;
  int checks = 0;
  logic [6:0] rows [20] = '{7'h09, 7'h0A, 7'h10, 7'h13, 7'h19, 7'h1A, 7'h20, 7'h25, 7'h2D, 7'h2A,
    7'h34, 7'h33, 7'h3D, 7'h3A, 7'h44, 7'h43, 7'h48, 7'h4D, 7'h4B, 7'h00};
  logic [7:0] fa [3] = '{8'h80, 8'h01, 8'h40};
  always #2.5 i_ref_clk = ~i_ref_clk;
  conditional_branch_unit dut (.*);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic load(logic [15:0] a);
    i_valid = 1'b0;
    i_alu_valid = 1'b1;
    i_alu_a = a;
    @(negedge i_ref_clk);
    i_alu_valid = 1'b0;
  endtask
  task automatic br(logic [3:0] op, logic [15:0] pc, logic [7:0] d, logic tk);
    i_valid = 1'b1;
    i_opcode = op;
    i_pc = pc;
    i_short_displacement = d;
    @(negedge i_ref_clk);
    chk("done", 16'(o_done), 16'h0001);
    chk("taken", 16'(o_taken), 16'(tk));
    chk("pc", o_next_pc, pc + (tk ? {{8{d[7]}}, d} : 16'h0000) + (op == 4'h9 ? 16'h0003 : 16'h0002));
  endtask
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_reset = 1'b0;
    foreach (rows[i]) begin
      load({8'h00, fa[rows[i][2:1]]});
      br(rows[i][6:3], 16'h1000 + 16'(i), i[0] ? 8'h80 : 8'h7F, rows[i][0]);
    end
    load(16'h0001);
    i_alu_word = 1'b1;
    i_alu_a = 16'h8000;
    i_alu_valid = 1'b1;
    br(4'h1, 16'hFF00, 8'h80, 1'b0);
    i_alu_valid = 1'b0;
    br(4'h1, 16'h00F0, 8'h7F, 1'b1);
    chk("flags", 16'({o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag}), 16'h0007);
    i_alu_word = 1'b0;
    i_alu_op = 2'h2;
    load(16'h0003);
    chk("logic", 16'({o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag}), 16'h0002);
    i_alu_op = 2'h1;
    load(16'h1234);
    chk("sub", 16'({o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag}), 16'h0004);
    i_valid = 1'b0;
    i_reset = 1'b1;
    @(negedge i_ref_clk);
    chk("reset", o_next_pc, 16'h0000);
    chk("rst_out", 16'({o_done, o_taken, o_sign_flag, o_zero_flag, o_parity_overflow_flag, o_carry_flag}), 16'h0000);
    final_report;
  end
endmodule
